/* logic/cadss_map.svh */
/*
 Register offsets, field positions, reset values and timing counts
 for the current sample selector and scaler.
 Assumes word-indexed registers on a plain strobe port.
*/
`ifndef CADSS_MAP_SVH
`define CADSS_MAP_SVH
// ----------------------------------------
// Register word indices
// ----------------------------------------
`define CADSS_A_CTRL   8'h00
`define CADSS_A_SEL    8'h01
`define CADSS_A_OFS0   8'h02
`define CADSS_A_OFS1   8'h03
`define CADSS_A_GAIN0  8'h04
`define CADSS_A_GAIN1  8'h05
`define CADSS_A_EXT0   8'h06
`define CADSS_A_EXT1   8'h07
`define CADSS_A_POLES  8'h08
`define CADSS_A_SHIFT  8'h09
`define CADSS_A_RAW0   8'h10
`define CADSS_A_RAW1   8'h11
`define CADSS_A_CUR0   8'h12
`define CADSS_A_CUR1   8'h13
`define CADSS_A_CUR2   8'h14
`define CADSS_A_SUPPLY 8'h15
`define CADSS_A_AIN    8'h16
`define CADSS_A_TFET   8'h17
`define CADSS_A_TMOT   8'h18
`define CADSS_A_ANGLE  8'h19
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CADSS_B_3PH    0
`define CADSS_B_Q412   1
`define CADSS_B_ELEC   2
`define CADSS_B_SUB    3
`define CADSS_F_RAW0   0
`define CADSS_F_RAW1   4
`define CADSS_F_UX     8
`define CADSS_F_V      10
`define CADSS_F_WY     12
// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define CADSS_R_CTRL   4'h1
`define CADSS_R_SEL    14'h2410
`define CADSS_R_GAIN   16'h0100
`define CADSS_R_POLES  8'h01
`define CADSS_FRAC_Q88  8
`define CADSS_FRAC_Q412 12
`define CADSS_LATENCY  2
`endif

/* logic/cadss_pkg.sv */
/*
 Types of the current sample selector and scaler.
 Assumes cadss_map.svh supplies the numeric constants.
*/
package cadss_pkg;
   typedef enum logic [2:0] {
      SRC_INT_U   = 3'h0,
      SRC_INT_V   = 3'h1,
      SRC_INT_UX  = 3'h2,
      SRC_INT_WY  = 3'h3,
      SRC_DS_UX   = 3'h4,
      SRC_DS_WY   = 3'h5,
      SRC_HOST0   = 3'h6,
      SRC_HOST1   = 3'h7
   } cadss_src_t;
   typedef enum logic [1:0] {
      RT_CUR0 = 2'h0,
      RT_CUR1 = 2'h1,
      RT_CUR2 = 2'h2,
      RT_NONE = 2'h3
   } cadss_route_t;
endpackage : cadss_pkg

/* logic/cadss_top.sv */
/*
 Current sample selector, offset and gain scaler, third phase
 derivation, phase routing and angle conversion.
 Assumes ADC samples and the sensor angle come from logic on core_clk_i.
*/
// Decided for this implementation: the register offsets and the address-and-strobe port.
// How it works
// - Internal results clip symmetrically; the most negative code becomes one above it.
// - Gains in q8.8 are signed 16 bit words with LSB 1/256.
// - Gains in q4.12 are signed 16 bit words with LSB 1/4096.
// - Gains are multiplied as signed operands with signed values.
// - Electrical angle is mechanical times pole pairs; mechanical is electrical over it.
// - The electrical angle is the commutation angle for the torque loop.
// - The mechanical angle feeds velocity and position control.
// - Angles are 16 bit, one turn is 65536 steps, signed or unsigned.
// - Adding the shift rotates forward modulo 16 bits; subtracting rotates back.
// - Every raw sample is widened to 16 bits.
// - Offset add and gain multiply are signed; negative gain inverts.
// - Scaled currents are readable; supply, temperatures and analog input stay raw.
// - Host written samples are selectable current sources.
// - Two selectors route one of eight sources to raw0 and raw1.
// - Each channel adds its offset, then multiplies by its gain.
// - Three phase mode derives a third current; two phase mode does not.
// - Three selectors route current 0, 1 or 2 to U/X, V and W/Y.
// - Three phase uses U/X, V, W/Y; two phase uses only U/X and W/Y.
`timescale 1ns/1ps
`include "cadss_map.svh"
module cadss_top #(
   parameter int ADC_W = 12
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   input  wire logic        sample_valid_i,
   input  wire logic [ADC_W-1:0] integrated_u_sample_i,
   input  wire logic [ADC_W-1:0] integrated_v_sample_i,
   input  wire logic [ADC_W-1:0] integrated_ux_sample_i,
   input  wire logic [ADC_W-1:0] integrated_wy_sample_i,
   input  wire logic [15:0] deltasigma_ux_sample_i,
   input  wire logic [15:0] deltasigma_wy_sample_i,
   input  wire logic [ADC_W-1:0] motor_supply_sample_i,
   input  wire logic [ADC_W-1:0] general_analog_sample_i,
   input  wire logic [ADC_W-1:0] fet_temp_sample_i,
   input  wire logic [ADC_W-1:0] motor_temp_sample_i,
   input  wire logic [15:0] sensor_angle_i,
   output logic             current_valid_o,
   output logic      [15:0] phase_ux_current_o,
   output logic      [15:0] phase_v_current_o,
   output logic      [15:0] phase_wy_current_o,
   output logic             three_phase_mode_o,
   output logic      [15:0] electrical_angle_o,
   output logic      [15:0] mechanical_angle_o
);
   initial begin
      if (ADC_W < 1 || ADC_W > 16) begin
         $error("ADC_W must lie in 1..16");
      end
   end

   // ----------------------------------------
   // Arithmetic helpers
   // ----------------------------------------
   function automatic logic signed [31:0] clip32(input logic signed [33:0] v);
      if (v > 34'sd2147483647) begin
         clip32 = 32'sh7FFF_FFFF;
      end else if (v < -34'sd2147483647) begin
         clip32 = -32'sh7FFF_FFFF;
      end else begin
         clip32 = v[31:0];
      end
   endfunction : clip32

   function automatic logic signed [15:0] clip16(input logic signed [31:0] v);
      if (v > 32'sd32767) begin
         clip16 = 16'sh7FFF;
      end else if (v < -32'sd32767) begin
         clip16 = 16'sh8001;
      end else begin
         clip16 = v[15:0];
      end
   endfunction : clip16

   // Offset, then signed gain in q8.8 or q4.12, then s16 saturation.
   function automatic logic signed [15:0] scale(
      input logic [15:0]        raw,
      input logic signed [15:0] ofs,
      input logic signed [15:0] gain,
      input logic               q412
   );
      logic signed [17:0] sum;
      logic signed [33:0] prod;
      logic signed [31:0] wide;
      sum  = $signed({2'b00, raw}) + 18'(ofs);
      prod = 34'(sum) * 34'(gain);
      wide = clip32(q412 ? (prod >>> `CADSS_FRAC_Q412)
                         : (prod >>> `CADSS_FRAC_Q88));
      scale = clip16(wide);
   endfunction : scale

   function automatic logic [15:0] widen(input logic [ADC_W-1:0] s);
      widen = 16'(s);
   endfunction : widen

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   logic [3:0]  ctrl_q;
   logic [13:0] sel_q;
   logic [15:0] ofs0_q;
   logic [15:0] ofs1_q;
   logic [15:0] gain0_q;
   logic [15:0] gain1_q;
   logic [15:0] host_written_sample0_q;
   logic [15:0] host_written_sample1_q;
   logic [7:0]  poles_q;
   logic [15:0] angle_shift_q;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ctrl_q        <= `CADSS_R_CTRL;
         sel_q         <= `CADSS_R_SEL;
         ofs0_q        <= 16'h0000;
         ofs1_q        <= 16'h0000;
         gain0_q       <= `CADSS_R_GAIN;
         gain1_q       <= `CADSS_R_GAIN;
         poles_q       <= `CADSS_R_POLES;
         angle_shift_q <= 16'h0000;
      end else if (wr_i) begin
         if (addr_i == `CADSS_A_CTRL) begin
            ctrl_q <= wdata_i[3:0];
         end else if (addr_i == `CADSS_A_SEL) begin
            sel_q <= wdata_i[13:0];
         end else if (addr_i == `CADSS_A_OFS0) begin
            ofs0_q <= wdata_i[15:0];
         end else if (addr_i == `CADSS_A_OFS1) begin
            ofs1_q <= wdata_i[15:0];
         end else if (addr_i == `CADSS_A_GAIN0) begin
            gain0_q <= wdata_i[15:0];
         end else if (addr_i == `CADSS_A_GAIN1) begin
            gain1_q <= wdata_i[15:0];
         end else if (addr_i == `CADSS_A_POLES) begin
            poles_q <= wdata_i[7:0];
         end else if (addr_i == `CADSS_A_SHIFT) begin
            angle_shift_q <= wdata_i[15:0];
         end
      end
   end

   // Host written current samples.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         host_written_sample0_q <= 16'h0000;
         host_written_sample1_q <= 16'h0000;
      end else if (wr_i && addr_i == `CADSS_A_EXT0) begin
         host_written_sample0_q <= wdata_i[15:0];
      end else if (wr_i && addr_i == `CADSS_A_EXT1) begin
         host_written_sample1_q <= wdata_i[15:0];
      end
   end

   // ----------------------------------------
   // Source selection
   // ----------------------------------------
   function automatic logic [15:0] pick(input logic [2:0] s);
      case (cadss_pkg::cadss_src_t'(s))
         cadss_pkg::SRC_INT_U:  pick = widen(integrated_u_sample_i);
         cadss_pkg::SRC_INT_V:  pick = widen(integrated_v_sample_i);
         cadss_pkg::SRC_INT_UX: pick = widen(integrated_ux_sample_i);
         cadss_pkg::SRC_INT_WY: pick = widen(integrated_wy_sample_i);
         cadss_pkg::SRC_DS_UX:  pick = deltasigma_ux_sample_i;
         cadss_pkg::SRC_DS_WY:  pick = deltasigma_wy_sample_i;
         cadss_pkg::SRC_HOST0:  pick = host_written_sample0_q;
         default:               pick = host_written_sample1_q;
      endcase
   endfunction : pick

   // ----------------------------------------
   // Stage 1: capture raw pair and configuration
   // ----------------------------------------
   logic [15:0] selected_raw0_q;
   logic [15:0] selected_raw1_q;
   logic [15:0] s_ofs0_q;
   logic [15:0] s_ofs1_q;
   logic [15:0] s_gain0_q;
   logic [15:0] s_gain1_q;
   logic [5:0]  s_route_q;
   logic        s_q412_q;
   logic        s_3ph_q;
   logic        stage1_q;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         selected_raw0_q <= 16'h0000;
         selected_raw1_q <= 16'h0000;
         s_ofs0_q        <= 16'h0000;
         s_ofs1_q        <= 16'h0000;
         s_gain0_q       <= 16'h0000;
         s_gain1_q       <= 16'h0000;
         s_route_q       <= 6'h00;
         s_q412_q        <= 1'b0;
         s_3ph_q         <= 1'b1;
      end else if (sample_valid_i) begin
         selected_raw0_q <= pick(sel_q[`CADSS_F_RAW0 +: 3]);
         selected_raw1_q <= pick(sel_q[`CADSS_F_RAW1 +: 3]);
         s_ofs0_q        <= ofs0_q;
         s_ofs1_q        <= ofs1_q;
         s_gain0_q       <= gain0_q;
         s_gain1_q       <= gain1_q;
         s_route_q       <= sel_q[`CADSS_F_UX +: 6];
         s_q412_q        <= ctrl_q[`CADSS_B_Q412];
         s_3ph_q         <= ctrl_q[`CADSS_B_3PH];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         stage1_q <= 1'b0;
      end else begin
         stage1_q <= sample_valid_i;
      end
   end

   // ----------------------------------------
   // Stage 2: scale, derive, route
   // ----------------------------------------
   logic signed [15:0] cur0_d;
   logic signed [15:0] cur1_d;
   logic signed [15:0] cur2_d;
   logic signed [15:0] scaled_current0_q;
   logic signed [15:0] scaled_current1_q;
   logic signed [15:0] derived_current2_q;

   always_comb begin
      cur0_d = scale(selected_raw0_q, s_ofs0_q, s_gain0_q, s_q412_q);
      cur1_d = scale(selected_raw1_q, s_ofs1_q, s_gain1_q, s_q412_q);
      if (s_3ph_q) begin
         cur2_d = clip16(-(32'(cur0_d) + 32'(cur1_d)));
      end else begin
         cur2_d = 16'sh0000;
      end
   end

   function automatic logic [15:0] route(input logic [1:0] r, input logic signed [15:0] c0,
                                         input logic signed [15:0] c1, input logic signed [15:0] c2);
      case (cadss_pkg::cadss_route_t'(r))
         cadss_pkg::RT_CUR0: route = c0;
         cadss_pkg::RT_CUR1: route = c1;
         cadss_pkg::RT_CUR2: route = c2;
         default:            route = 16'h0000;
      endcase
   endfunction : route

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         scaled_current0_q  <= 16'sh0000;
         scaled_current1_q  <= 16'sh0000;
         derived_current2_q <= 16'sh0000;
         phase_ux_current_o <= 16'h0000;
         phase_v_current_o  <= 16'h0000;
         phase_wy_current_o <= 16'h0000;
         three_phase_mode_o <= 1'b1;
      end else if (stage1_q) begin
         scaled_current0_q  <= cur0_d;
         scaled_current1_q  <= cur1_d;
         derived_current2_q <= cur2_d;
         phase_ux_current_o <= route(s_route_q[1:0], cur0_d, cur1_d, cur2_d);
         phase_v_current_o  <= s_3ph_q ? route(s_route_q[3:2], cur0_d, cur1_d, cur2_d) : 16'h0000;
         phase_wy_current_o <= route(s_route_q[5:4], cur0_d, cur1_d, cur2_d);
         three_phase_mode_o <= s_3ph_q;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         current_valid_o <= 1'b0;
      end else begin
         current_valid_o <= stage1_q;
      end
   end

   // ----------------------------------------
   // Angle conversion
   // ----------------------------------------
   logic [15:0] npp;
   logic [15:0] rot_shift;
   logic [15:0] elec_base;
   logic [15:0] mech_d;

   always_comb begin
      npp = (poles_q == 8'h00) ? 16'h0001 : 16'(poles_q);
      rot_shift = ctrl_q[`CADSS_B_SUB] ? 16'(-angle_shift_q) : angle_shift_q;
      if (ctrl_q[`CADSS_B_ELEC]) begin
         elec_base = sensor_angle_i;
         mech_d    = sensor_angle_i / npp;
      end else begin
         elec_base = 16'(sensor_angle_i * npp);
         mech_d    = sensor_angle_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         electrical_angle_o <= 16'h0000;
         mechanical_angle_o <= 16'h0000;
      end else begin
         electrical_angle_o <= 16'(elec_base + rot_shift);
         mechanical_angle_o <= mech_d;
      end
   end

   // ----------------------------------------
   // Register read port
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (rd_i) begin
         if (addr_i == `CADSS_A_CTRL) begin
            rdata_o <= 32'(ctrl_q);
         end else if (addr_i == `CADSS_A_SEL) begin
            rdata_o <= 32'(sel_q);
         end else if (addr_i == `CADSS_A_OFS0) begin
            rdata_o <= 32'(ofs0_q);
         end else if (addr_i == `CADSS_A_OFS1) begin
            rdata_o <= 32'(ofs1_q);
         end else if (addr_i == `CADSS_A_GAIN0) begin
            rdata_o <= 32'(gain0_q);
         end else if (addr_i == `CADSS_A_GAIN1) begin
            rdata_o <= 32'(gain1_q);
         end else if (addr_i == `CADSS_A_EXT0) begin
            rdata_o <= 32'(host_written_sample0_q);
         end else if (addr_i == `CADSS_A_EXT1) begin
            rdata_o <= 32'(host_written_sample1_q);
         end else if (addr_i == `CADSS_A_POLES) begin
            rdata_o <= 32'(poles_q);
         end else if (addr_i == `CADSS_A_SHIFT) begin
            rdata_o <= 32'(angle_shift_q);
         end else if (addr_i == `CADSS_A_RAW0) begin
            rdata_o <= 32'(selected_raw0_q);
         end else if (addr_i == `CADSS_A_RAW1) begin
            rdata_o <= 32'(selected_raw1_q);
         end else if (addr_i == `CADSS_A_CUR0) begin
            rdata_o <= 32'(unsigned'(scaled_current0_q));
         end else if (addr_i == `CADSS_A_CUR1) begin
            rdata_o <= 32'(unsigned'(scaled_current1_q));
         end else if (addr_i == `CADSS_A_CUR2) begin
            rdata_o <= 32'(unsigned'(derived_current2_q));
         end else if (addr_i == `CADSS_A_SUPPLY) begin
            rdata_o <= 32'(widen(motor_supply_sample_i));
         end else if (addr_i == `CADSS_A_AIN) begin
            rdata_o <= 32'(widen(general_analog_sample_i));
         end else if (addr_i == `CADSS_A_TFET) begin
            rdata_o <= 32'(widen(fet_temp_sample_i));
         end else if (addr_i == `CADSS_A_TMOT) begin
            rdata_o <= 32'(widen(motor_temp_sample_i));
         end else if (addr_i == `CADSS_A_ANGLE) begin
            rdata_o <= {mechanical_angle_o, electrical_angle_o};
         end else begin
            rdata_o <= 32'h0000_0000;
         end
      end else begin
         rdata_o <= 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_no_min_code;
      @(posedge core_clk_i) disable iff (rst_i)
      current_valid_o |-> (scaled_current0_q != 16'sh8000) && (derived_current2_q != 16'sh8000);
   endproperty
   a_no_min_code: assert property (p_no_min_code) else $error("s16 min code reached output");

   property p_latency;
      @(posedge core_clk_i) disable iff (rst_i)
      sample_valid_i |-> ##2 current_valid_o;
   endproperty
   a_latency: assert property (p_latency) else $error("current update latency wrong");

   property p_kirchhoff;
      @(posedge core_clk_i) disable iff (rst_i)
      stage1_q && s_3ph_q && cur0_d != 16'sh8001 && cur1_d > -16'sd16000 && cur1_d < 16'sd16000
         && cur0_d > -16'sd16000 && cur0_d < 16'sd16000
      |=> 16'(scaled_current0_q + scaled_current1_q + derived_current2_q) == 16'h0000;
   endproperty
   a_kirchhoff: assert property (p_kirchhoff) else $error("derived current breaks sum");

   property p_two_phase;
      @(posedge core_clk_i) disable iff (rst_i)
      stage1_q && !s_3ph_q |=> derived_current2_q == 16'sh0000 && phase_v_current_o == 16'h0000;
   endproperty
   a_two_phase: assert property (p_two_phase) else $error("two phase mode drives third current");

   property p_route_ux;
      @(posedge core_clk_i) disable iff (rst_i)
      stage1_q && s_route_q[1:0] == 2'h1 |=> phase_ux_current_o == scaled_current1_q;
   endproperty
   a_route_ux: assert property (p_route_ux) else $error("U/X routing wrong");

   property p_raw_select;
      @(posedge core_clk_i) disable iff (rst_i)
      sample_valid_i && sel_q[2:0] == 3'h6 |=> selected_raw0_q == $past(host_written_sample0_q);
   endproperty
   a_raw_select: assert property (p_raw_select) else $error("host sample not selected");

   property p_cfg_hold;
      @(posedge core_clk_i) disable iff (rst_i)
      !sample_valid_i |=> $stable(s_gain0_q) && $stable(s_ofs1_q);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("shadow config moved between updates");

   property p_neg_gain;
      @(posedge core_clk_i) disable iff (rst_i)
      stage1_q && s_gain0_q == 16'hFF00 && !s_q412_q && selected_raw0_q < 16'h8000 && s_ofs0_q == 16'h0000
      |=> scaled_current0_q == 16'(16'h0000 - $past(selected_raw0_q));
   endproperty
   a_neg_gain: assert property (p_neg_gain) else $error("negative gain did not invert");

   property p_angle;
      @(posedge core_clk_i) disable iff (rst_i)
      !rst_i && !ctrl_q[`CADSS_B_ELEC] && !ctrl_q[`CADSS_B_SUB] && $stable(ctrl_q) && poles_q != 8'h00
      |=> electrical_angle_o == 16'($past(sensor_angle_i) * 16'($past(poles_q)) + $past(angle_shift_q));
   endproperty
   a_angle: assert property (p_angle) else $error("electrical angle mismatch");
endmodule : cadss_top

/* testbench/cadss_adc_model.sv */
/*
 Model of the current and monitor converters that feed the sample selector.
 Assumes one clock shared with the design and a trigger from the bench.
*/
`timescale 1ns/1ps
module cadss_adc_model (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        trig_i,
   input  wire logic [15:0] base_i,
   output logic             sample_valid_o,
   output logic      [11:0] int_u_o,
   output logic      [11:0] int_v_o,
   output logic      [11:0] int_ux_o,
   output logic      [11:0] int_wy_o,
   output logic      [15:0] ds_ux_o,
   output logic      [15:0] ds_wy_o,
   output logic      [11:0] supply_o,
   output logic      [11:0] temp_o
);
   logic [15:0] b_q;
   // Outside the valid cycle the lines toggle, so stale data never looks valid.
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         sample_valid_o <= 1'b0;
         b_q            <= 16'h0000;
      end else if (trig_i) begin
         sample_valid_o <= 1'b1;
         b_q            <= base_i;
      end else begin
         sample_valid_o <= 1'b0;
         b_q            <= ~b_q;
      end
   end
   assign int_u_o  = b_q[11:0];
   assign int_v_o  = ~b_q[11:0];
   assign int_ux_o = b_q[11:0] + 12'h001;
   assign int_wy_o = b_q[11:0] + 12'h002;
   assign ds_ux_o  = b_q;
   assign ds_wy_o  = ~b_q;
   assign supply_o = b_q[11:0] ^ 12'h0F0;
   assign temp_o   = b_q[11:0] ^ 12'h00F;
endmodule : cadss_adc_model

/* testbench/current_adc_select_scale_tb.sv */
/*
 Self-checking bench of the current sample selector and scaler.
 Assumes cadss_top with ADC_W of 12 and the converter model beside it.
*/
`timescale 1ns/1ps
`include "cadss_map.svh"
module current_adc_select_scale_tb;
   typedef struct packed {
      logic [2:0]  s0;
      logic [2:0]  s1;
      logic [15:0] o0;
      logic [15:0] o1;
      logic [15:0] g0;
      logic [15:0] g1;
      logic [15:0] b;
      logic [3:0]  c;
   } cadss_row_t;
   localparam logic [15:0] EXT0 = 16'h1234;
   localparam logic [15:0] EXT1 = 16'hFEDC;
   logic        core_clk_i, rst_i, wr_i, rd_i, trig, sv, cv, tpm;
   logic [7:0]  addr_i;
   logic [31:0] wdata_i, rdata_o;
   logic [15:0] base, ang, ux, v, wy, ea, ma, dsu, dsw;
   logic [11:0] iu, iv, iux, iwy, sup, tmp;
   int          num_errors, compares;
   cadss_row_t  rows [5];
   cadss_top #(.ADC_W(12)) u_cadss_top (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sample_valid_i(sv),
      .integrated_u_sample_i(iu), .integrated_v_sample_i(iv), .integrated_ux_sample_i(iux),
      .integrated_wy_sample_i(iwy), .deltasigma_ux_sample_i(dsu), .deltasigma_wy_sample_i(dsw),
      .motor_supply_sample_i(sup), .general_analog_sample_i(tmp), .fet_temp_sample_i(tmp),
      .motor_temp_sample_i(tmp), .sensor_angle_i(ang), .current_valid_o(cv), .phase_ux_current_o(ux),
      .phase_v_current_o(v), .phase_wy_current_o(wy), .three_phase_mode_o(tpm),
      .electrical_angle_o(ea), .mechanical_angle_o(ma));
   cadss_adc_model u_cadss_adc_model (.core_clk_i(core_clk_i), .rst_i(rst_i), .trig_i(trig),
      .base_i(base), .sample_valid_o(sv), .int_u_o(iu), .int_v_o(iv), .int_ux_o(iux), .int_wy_o(iwy),
      .ds_ux_o(dsu), .ds_wy_o(dsw), .supply_o(sup), .temp_o(tmp));
   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge core_clk_i);
      wr_i    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge core_clk_i);
      rd_i   <= 1'b0;
      #10 d = rdata_o;
   endtask : rd
   function automatic logic [15:0] sat(input longint p);
      if (p > 32767) p = 32767;
      if (p < -32767) p = -32767;
      return p[15:0];
   endfunction : sat
   function automatic logic [15:0] scl(input logic [15:0] r, input logic [15:0] o, input logic [15:0] g,
                                       input logic q);
      longint p;
      p = (longint'(r) + longint'($signed(o))) * longint'($signed(g));
      return sat(p >>> (q ? 12 : 8));
   endfunction : scl
   function automatic logic [15:0] rv(input logic [2:0] s, input logic [15:0] b);
      case (s)
         3'h0: return {4'h0, b[11:0]};
         3'h1: return {4'h0, ~b[11:0]};
         3'h2: return {4'h0, b[11:0] + 12'h001};
         3'h3: return {4'h0, b[11:0] + 12'h002};
         3'h4: return b;
         3'h5: return ~b;
         3'h6: return EXT0;
         default: return EXT1;
      endcase
   endfunction : rv
   task automatic samp();
      int n;
      @(posedge core_clk_i);
      trig <= 1'b1;
      @(posedge core_clk_i);
      trig <= 1'b0;
      n = 0;
      while (cv !== 1'b1 && n < 8) begin
         @(negedge core_clk_i);
         n++;
      end
      chk(cv, 1'b1);
   endtask : samp
   task automatic run_row(input cadss_row_t r, input logic [5:0] rt);
      logic [15:0] e [4];
      logic [31:0] d;
      wr(`CADSS_A_CTRL, {28'h000_0000, r.c});
      wr(`CADSS_A_SEL, {18'h0_0000, rt, 1'b0, r.s1, 1'b0, r.s0});
      wr(`CADSS_A_OFS0, {16'h0000, r.o0});
      wr(`CADSS_A_OFS1, {16'h0000, r.o1});
      wr(`CADSS_A_GAIN0, {16'h0000, r.g0});
      wr(`CADSS_A_GAIN1, {16'h0000, r.g1});
      base <= r.b;
      samp();
      e[0] = scl(rv(r.s0, r.b), r.o0, r.g0, r.c[1]);
      e[1] = scl(rv(r.s1, r.b), r.o1, r.g1, r.c[1]);
      e[2] = r.c[0] ? sat(-(longint'($signed(e[0])) + longint'($signed(e[1])))) : 16'h0000;
      e[3] = 16'h0000;
      chk(ux, e[rt[1:0]]);
      chk(v, r.c[0] ? e[rt[3:2]] : 16'h0000);
      chk(wy, e[rt[5:4]]);
      chk(tpm, r.c[0]);
      rd(`CADSS_A_RAW1, d);
      chk(d, rv(r.s1, r.b));
      // The monitor lines toggle every cycle, so this read catches the inverted base.
      rd(`CADSS_A_SUPPLY, d);
      chk(d, {20'h0_0000, ~r.b[11:0] ^ 12'h0F0});
      wr(`CADSS_A_CUR0, 32'hFFFF_FFFF);
      rd(`CADSS_A_CUR0, d);
      chk(d, e[0]);
   endtask : run_row
   task automatic do_reset();
      logic [31:0] d;
      logic [39:0] tbl [7];
      tbl = '{{8'h00, 32'h0000_0001}, {8'h01, 32'h0000_2410}, {8'h04, 32'h0000_0100},
              {8'h05, 32'h0000_0100}, {8'h08, 32'h0000_0001}, {8'h02, 32'h0000_0000}, {8'h30, 32'h0000_0000}};
      rst_i <= 1'b1;
      repeat (5) @(posedge core_clk_i);
      rst_i <= 1'b0;
      #10 chk(cv, 1'b0);
      chk(ux, 16'h0000);
      chk(tpm, 1'b1);
      foreach (tbl[i]) begin
         rd(tbl[i][39:32], d);
         chk(d, tbl[i][31:0]);
      end
      $display("test reset done");
   endtask : do_reset
   task automatic angle(input logic [3:0] c, input logic m, input logic [15:0] exp);
      wr(`CADSS_A_CTRL, {28'h000_0000, c});
      repeat (3) @(posedge core_clk_i);
      #10 chk(m ? ma : ea, exp);
   endtask : angle
   task automatic test_done();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done
   initial begin
      #3_000_000;
      num_errors++;
      test_done();
   end
   initial begin
      {wr_i, rd_i, trig, addr_i, wdata_i, base, ang} <= '0;
      num_errors = 0;
      compares = 0;
      rows = '{{3'h0, 3'h1, 16'hF800, 16'hF800, 16'h0100, 16'h0100, 16'h0123, 4'h1},
               {3'h2, 3'h3, 16'h0000, 16'h0000, 16'hFF00, 16'h0200, 16'h0456, 4'h1},
               {3'h4, 3'h5, 16'h0000, 16'h8000, 16'h7FFF, 16'h0100, 16'hFFFF, 4'h1},
               {3'h6, 3'h7, 16'h1000, 16'hF000, 16'h1000, 16'h0800, 16'h0000, 4'h3},
               {3'h1, 3'h6, 16'h0010, 16'h0000, 16'h0100, 16'h0100, 16'h0ABC, 4'h0}};
      do_reset();
      wr(`CADSS_A_EXT0, {16'h0000, EXT0});
      wr(`CADSS_A_EXT1, {16'h0000, EXT1});
      foreach (rows[i]) run_row(rows[i], 6'h24);
      $display("test table done");
      for (int r = 0; r < 4; r++) begin
         run_row(rows[0], {2'(r + 2), 2'(r + 1), 2'(r)});
      end
      $display("test routing done");
      wr(`CADSS_A_POLES, 32'h0000_0003);
      wr(`CADSS_A_SHIFT, 32'h0000_1000);
      @(posedge core_clk_i);
      ang <= 16'h6000;
      angle(4'h1, 1'b0, 16'h3000);
      angle(4'h9, 1'b0, 16'h1000);
      angle(4'h5, 1'b1, 16'h2000);
      $display("test angle done");
      do_reset();
      test_done();
   end
endmodule : current_adc_select_scale_tb
